// ### ref_output_consts.vh
// Address map, field layout and delay figures of the reference-output bank
`ifndef REF_OUTPUT_CONSTS_VH
`define REF_OUTPUT_CONSTS_VH

// Register offsets
`define ADDR_DELAY_SELECT_A0 8'h28
`define ADDR_DELAY_SELECT_A1 8'h29
`define ADDR_DELAY_SELECT_A2 8'h2a
`define ADDR_OUTPUT_FORMAT_A0 8'h2c
`define ADDR_OUTPUT_FORMAT_A1 8'h2d
`define ADDR_OUTPUT_FORMAT_A2 8'h2e
`define ADDR_DELAY_SELECT_B0 8'h38
`define ADDR_DELAY_SELECT_B1 8'h39
`define ADDR_OUTPUT_FORMAT_B0 8'h3c
`define ADDR_OUTPUT_FORMAT_B1 8'h3d
`define ADDR_DELAY_SELECT_C 8'h49
`define ADDR_OUTPUT_FORMAT_C 8'h4d
`define ADDR_DELAY_SELECT_D 8'h58
`define ADDR_OUTPUT_FORMAT_D 8'h5c
`define ADDR_OUTPUT_ENABLES 8'h76

// Enable bit positions in the shared enable register
`define EN_BIT_A0 3'h7
`define EN_BIT_A1 3'h6
`define EN_BIT_A2 3'h5
`define EN_BIT_B0 3'h4
`define EN_BIT_B1 3'h3
`define EN_BIT_C 3'h1
`define EN_BIT_D 3'h0

// Writable bits and reset values
`define DELAY_SELECT_MASK 8'h7f
`define OUTPUT_FORMAT_MASK 8'hbc
`define OUTPUT_ENABLES_MASK 8'hfb
`define DELAY_SELECT_RESET 8'h10
`define OUTPUT_FORMAT_RESET 8'h00
`define OUTPUT_ENABLES_RESET 8'h00

// Field positions of the delay/select register
`define FLD_FINE_LO_HI 6
`define FLD_FINE_LO_LO 5
`define FLD_SOURCE_SELECT 4
`define FLD_COARSE_HI 3
`define FLD_COARSE_LO 1
`define FLD_FINE_HI 0

// Field positions of the format register
`define FLD_POWER_DOWN 7
`define FLD_BIAS_ENABLE 5
`define FLD_FORMAT 4
`define FLD_AMP_HI 3
`define FLD_AMP_LO 2

// Delay figures in picoseconds
`define COARSE_STEP_PS 12'd407
`define FINE_PS_0 12'd0
`define FINE_PS_1 12'd25
`define FINE_PS_2 12'd50
`define FINE_PS_3 12'd75
`define FINE_PS_4 12'd85
`define FINE_PS_5 12'd110
`define FINE_PS_6 12'd135
`define FINE_PS_7 12'd160

`endif

// ### ref_output_slot.v
// One reference output: its two byte registers, enable bit and steering
`timescale 1ns/1ns
`default_nettype none
`include "ref_output_consts.vh"

module ref_output_slot #(
  parameter [7:0] DELAY_ADDR = 8'h00,
  parameter [7:0] FORMAT_ADDR = 8'h00,
  parameter [2:0] EN_BIT = 3'h0
) (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Register write port
  input wire i_wr,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  // Signal sources
  input wire i_channel_ref,
  input wire i_central_sysref,
  // Register contents for readback
  output reg [7:0] o_delay_reg,
  output reg [7:0] o_format_reg,
  output reg o_enable,
  // Steered state
  output reg o_reference_output,
  output reg o_active,
  output reg o_source_select,
  output reg [11:0] o_delay_ps,
  output reg o_power_down,
  output reg o_bias_enable,
  output reg o_format,
  output reg [1:0] o_amplitude
);

  wire sel;
  wire pd;
  wire [2:0] coarse;
  wire [2:0] fine;
  reg [11:0] fine_ps;
  wire [11:0] coarse_ps;

  assign sel = o_delay_reg[`FLD_SOURCE_SELECT];
  assign coarse = o_delay_reg[`FLD_COARSE_HI:`FLD_COARSE_LO];
  // Fine code is split: bit 2 sits at D0, bits 1:0 at D6:D5
  assign fine = {o_delay_reg[`FLD_FINE_HI],
                 o_delay_reg[`FLD_FINE_LO_HI:`FLD_FINE_LO_LO]};
  assign pd = o_format_reg[`FLD_POWER_DOWN];
  assign coarse_ps = {9'h000, coarse} * `COARSE_STEP_PS;

  // Fine steps are not uniform above code 3
  always @* begin
    case (fine)
      3'h0: fine_ps = `FINE_PS_0;
      3'h1: fine_ps = `FINE_PS_1;
      3'h2: fine_ps = `FINE_PS_2;
      3'h3: fine_ps = `FINE_PS_3;
      3'h4: fine_ps = `FINE_PS_4;
      3'h5: fine_ps = `FINE_PS_5;
      3'h6: fine_ps = `FINE_PS_6;
      default: fine_ps = `FINE_PS_7;
    endcase
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_delay_reg <= `DELAY_SELECT_RESET;
      o_format_reg <= `OUTPUT_FORMAT_RESET;
      o_enable <= 1'b0;
    end else begin
      if (i_wr && i_addr == DELAY_ADDR) begin
        o_delay_reg <= i_wdata & `DELAY_SELECT_MASK;
      end
      if (i_wr && i_addr == FORMAT_ADDR) begin
        o_format_reg <= i_wdata & `OUTPUT_FORMAT_MASK;
      end
      if (i_wr && i_addr == `ADDR_OUTPUT_ENABLES) begin
        o_enable <= i_wdata[EN_BIT];
      end
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reference_output <= 1'b0;
      o_active <= 1'b0;
      o_source_select <= 1'b1;
      o_delay_ps <= 12'h000;
      o_power_down <= 1'b0;
      o_bias_enable <= 1'b0;
      o_format <= 1'b0;
      o_amplitude <= 2'h0;
    end else begin
      // Powered-down output holds low; enable, format, amplitude masked
      o_reference_output <= !pd && o_enable &&
                            (sel ? i_central_sysref : i_channel_ref);
      o_active <= o_enable && !pd;
      o_source_select <= sel;
      o_delay_ps <= coarse_ps + fine_ps;
      o_power_down <= pd;
      o_bias_enable <= o_format_reg[`FLD_BIAS_ENABLE];
      o_format <= pd ? 1'b0 : o_format_reg[`FLD_FORMAT];
      o_amplitude <= pd ? 2'h0 :
                     o_format_reg[`FLD_AMP_HI:`FLD_AMP_LO];
    end
  end

endmodule // ref_output_slot

`default_nettype wire

// ### ref_regs_chk.sv
// Port assertions for the reference-output register bank
`timescale 1ns/1ns
`default_nettype none
module ref_regs_chk (
  // Clock, reset and register port
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_rdata_valid,
  // Sources and steered state
  input wire logic [6:0] i_channel_ref,
  input wire logic i_central_sysref,
  input wire logic [6:0] o_reference_output,
  input wire logic [6:0] o_ref_output_active,
  input wire logic [6:0] o_ref_source_select,
  input wire logic [83:0] o_ref_delay_ps,
  input wire logic [6:0] o_ref_output_power_down
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Fine steps are 25 ps apart but the upper half starts at 85, not 100
  function automatic logic [11:0] dly(input logic [7:0] v);
    logic [2:0] f;
    f = {v[0], v[6:5]};
    return v[3:1] * 12'd407 + f * 12'd25 - (f[2] ? 12'd15 : 12'd0);
  endfunction
  AST_RD_VALID: assert property (i_rd |=> o_rdata_valid)
    else $error("read without valid");
  AST_NO_VALID: assert property (!i_rd |=> !o_rdata_valid)
    else $error("valid without read");
  AST_RSV_ZERO: assert property (
    i_rd && i_addr == 8'h2c |=> (o_rdata & 8'h43) == 8'h00)
    else $error("reserved format bits read nonzero");
  AST_RESET: assert property (
    !$past(i_reset_n) |-> o_ref_source_select == 7'h7f
    && o_ref_delay_ps == 84'h0)
    else $error("wrong state after reset");
  AST_SEL_WR: assert property (
    i_wr && i_addr == 8'h28
    |=> ##1 o_ref_source_select[0] == $past(i_wdata[4], 2))
    else $error("select bit not applied");
  AST_DLY_WR: assert property (
    i_wr && i_addr == 8'h28
    |=> ##1 o_ref_delay_ps[11:0] == dly($past(i_wdata, 2)))
    else $error("delay figure wrong");
  AST_PD_MASK: assert property (
    o_ref_output_power_down[0] |-> !o_ref_output_active[0])
    else $error("powered-down output active");
  AST_SRC: assert property (
    $stable(o_ref_source_select[0]) && $stable(o_ref_output_active[0])
    |-> o_reference_output[0] == (o_ref_output_active[0]
    && (o_ref_source_select[0] ? $past(i_central_sysref)
    : $past(i_channel_ref[0]))))
    else $error("output source wrong");
  cover property (i_wr && i_addr == 8'h2c);
  cover property (o_ref_output_power_down[0]);
  cover property ($rose(o_reference_output[0]));
endmodule // ref_regs_chk
bind sysref_output_state_regs ref_regs_chk i_ref_regs_chk (.*);
`default_nettype wire

// ### sysref_output_state_regs.v
// Register bank for the seven reference (SYSREF) outputs
`timescale 1ns/1ns
`default_nettype none
`include "ref_output_consts.vh"

module sysref_output_state_regs (
  // Clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // Register port from the serial configuration engine
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  output reg [7:0] o_rdata,
  output reg o_rdata_valid,
  // Signal sources, order d,c,b1,b0,a2,a1,a0 from bit 6 to 0
  input wire [6:0] i_channel_ref,
  input wire i_central_sysref,
  // Per-output steered state, same order
  output wire [6:0] o_reference_output,
  output wire [6:0] o_ref_output_active,
  output wire [6:0] o_ref_source_select,
  output wire [83:0] o_ref_delay_ps,
  output wire [6:0] o_ref_output_power_down,
  output wire [6:0] o_ref_output_bias_enable,
  output wire [6:0] o_ref_output_format,
  output wire [13:0] o_ref_output_amplitude
);

  localparam [55:0] DELAY_ADDRS = {
    `ADDR_DELAY_SELECT_D, `ADDR_DELAY_SELECT_C,
    `ADDR_DELAY_SELECT_B1, `ADDR_DELAY_SELECT_B0,
    `ADDR_DELAY_SELECT_A2, `ADDR_DELAY_SELECT_A1,
    `ADDR_DELAY_SELECT_A0};
  localparam [55:0] FORMAT_ADDRS = {
    `ADDR_OUTPUT_FORMAT_D, `ADDR_OUTPUT_FORMAT_C,
    `ADDR_OUTPUT_FORMAT_B1, `ADDR_OUTPUT_FORMAT_B0,
    `ADDR_OUTPUT_FORMAT_A2, `ADDR_OUTPUT_FORMAT_A1,
    `ADDR_OUTPUT_FORMAT_A0};
  localparam [20:0] EN_BITS = {
    `EN_BIT_D, `EN_BIT_C, `EN_BIT_B1, `EN_BIT_B0,
    `EN_BIT_A2, `EN_BIT_A1, `EN_BIT_A0};

  wire [55:0] delay_regs;
  wire [55:0] format_regs;
  wire [6:0] enables;
  reg [7:0] next_rdata;
  reg [7:0] enable_word;
  integer k;

  genvar i;
  generate
    for (i = 0; i < 7; i = i + 1) begin : slot
      ref_output_slot #(
        .DELAY_ADDR(DELAY_ADDRS[i*8 +: 8]),
        .FORMAT_ADDR(FORMAT_ADDRS[i*8 +: 8]),
        .EN_BIT(EN_BITS[i*3 +: 3])
      ) u_slot (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_wr(i_wr),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_channel_ref(i_channel_ref[i]),
        .i_central_sysref(i_central_sysref),
        .o_delay_reg(delay_regs[i*8 +: 8]),
        .o_format_reg(format_regs[i*8 +: 8]),
        .o_enable(enables[i]),
        .o_reference_output(o_reference_output[i]),
        .o_active(o_ref_output_active[i]),
        .o_source_select(o_ref_source_select[i]),
        .o_delay_ps(o_ref_delay_ps[i*12 +: 12]),
        .o_power_down(o_ref_output_power_down[i]),
        .o_bias_enable(o_ref_output_bias_enable[i]),
        .o_format(o_ref_output_format[i]),
        .o_amplitude(o_ref_output_amplitude[i*2 +: 2])
      );
    end
  endgenerate

  // Readback mux; unmapped addresses and reserved bits read zero
  always @* begin
    enable_word = `OUTPUT_ENABLES_RESET;
    next_rdata = 8'h00;
    for (k = 0; k < 7; k = k + 1) begin
      enable_word[EN_BITS[k*3 +: 3]] = enables[k];
      if (i_addr == DELAY_ADDRS[k*8 +: 8]) begin
        next_rdata = delay_regs[k*8 +: 8];
      end
      if (i_addr == FORMAT_ADDRS[k*8 +: 8]) begin
        next_rdata = format_regs[k*8 +: 8];
      end
    end
    if (i_addr == `ADDR_OUTPUT_ENABLES) begin
      next_rdata = enable_word & `OUTPUT_ENABLES_MASK;
    end
  end

  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
      o_rdata_valid <= 1'b0;
    end else begin
      o_rdata_valid <= i_rd;
      if (i_rd) begin
        o_rdata <= next_rdata;
      end
    end
  end

endmodule // sysref_output_state_regs

`default_nettype wire

// ### tb_sysref_output_state_regs.sv
// Self-checking bench for the reference-output register bank
`timescale 1ns/1ns
`default_nettype none
module tb_sysref_output_state_regs;
  logic i_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_central_sysref = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [6:0] i_channel_ref = 7'h00;
  logic [7:0] o_rdata;
  logic o_rdata_valid;
  logic [6:0] o_reference_output, o_ref_output_active, o_ref_source_select;
  logic [6:0] o_ref_output_power_down, o_ref_output_bias_enable;
  logic [6:0] o_ref_output_format;
  logic [83:0] o_ref_delay_ps;
  logic [13:0] o_ref_output_amplitude;
  int miscompares = 0;
  int compares = 0;
  sysref_output_state_regs i_sysref_output_state_regs (
    .i_clk, .i_reset_n, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
    .o_rdata_valid, .i_channel_ref, .i_central_sysref, .o_reference_output,
    .o_ref_output_active, .o_ref_source_select, .o_ref_delay_ps,
    .o_ref_output_power_down, .o_ref_output_bias_enable,
    .o_ref_output_format, .o_ref_output_amplitude);
  always #25 i_clk = ~i_clk;
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Entered at a falling edge, returns two falling edges later
  // Idle cycle keeps back-to-back calls from re-raising a strobe at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_clk);
    i_wr = 1'b0;
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    i_rd = 1'b1;
    i_addr = a;
    @(negedge i_clk);
    i_rd = 1'b0;
    chk(o_rdata_valid, 1'b1);
    chk(o_rdata, exp);
    @(negedge i_clk);
    chk(o_rdata_valid, 1'b0);
  endtask
  task automatic t_reset;
    logic [7:0] da [7] = '{8'h28, 8'h29, 8'h2a, 8'h38, 8'h39, 8'h49, 8'h58};
    chk(o_ref_source_select, 7'h7f);
    chk(o_ref_delay_ps[11:0], 12'h000);
    for (int i = 0; i < 7; i++) begin
      rd(da[i], 8'h10);
      rd(da[i] + 8'h04, 8'h00);
    end
    rd(8'h76, 8'h00);
  endtask
  task automatic t_delay;
    logic [2:0] f;
    logic [11:0] fine [8] = '{0, 25, 50, 75, 85, 110, 135, 160};
    for (int c = 0; c < 8; c++) begin
      f = 3'(7 - c);
      wr(8'h28, {1'b1, f[1:0], 1'b1, 3'(c), f[2]});
      repeat (2) @(negedge i_clk);
      chk(o_ref_delay_ps[11:0], 12'(c) * 12'd407 + fine[f]);
      rd(8'h28, {1'b0, f[1:0], 1'b1, 3'(c), f[2]});
    end
  endtask
  task automatic t_rsv;
    wr(8'h2c, 8'hff);
    rd(8'h2c, 8'hbc);
    wr(8'h76, 8'hff);
    rd(8'h76, 8'hfb);
    wr(8'h30, 8'hff);
    rd(8'h30, 8'h00);
    wr(8'h58, 8'hff);
    rd(8'h58, 8'h7f);
    chk(o_ref_delay_ps[83:72], 12'd7 * 12'd407 + 12'd160);
    chk(o_ref_source_select[6], 1'b1);
  endtask
  task automatic t_src;
    wr(8'h2c, 8'h3c);
    i_central_sysref = 1'b1;
    repeat (3) @(negedge i_clk);
    chk(o_reference_output[0], 1'b1);
    chk(o_ref_output_format[0], 1'b1);
    chk(o_ref_output_amplitude[1:0], 2'h3);
    chk(o_ref_output_active, 7'h7f);
    wr(8'h28, 8'h00);
    repeat (3) @(negedge i_clk);
    chk(o_reference_output[0], 1'b0);
    i_channel_ref = 7'h01;
    repeat (2) @(negedge i_clk);
    chk(o_reference_output[0], 1'b1);
    wr(8'h2c, 8'hbc);
    repeat (3) @(negedge i_clk);
    chk(o_reference_output[0], 1'b0);
    chk(o_ref_output_format[0], 1'b0);
    chk(o_ref_output_amplitude[1:0], 2'h0);
    chk(o_ref_output_bias_enable[0], 1'b1);
    chk(o_ref_output_active[0], 1'b0);
    chk(o_ref_output_power_down[0], 1'b1);
  endtask
  task automatic summarize;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge i_clk);
    i_reset_n = 1'b1;
    @(negedge i_clk);
    t_reset();
    t_delay();
    t_rsv();
    t_src();
    i_reset_n = 1'b0;
    @(negedge i_clk);
    chk(o_ref_source_select, 7'h7f);
    i_reset_n = 1'b1;
    @(negedge i_clk);
    rd(8'h58, 8'h10);
    summarize();
  end
  // Whole run is some 126 cycles
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
endmodule // tb_sysref_output_state_regs
`default_nettype wire
